// *** pkg/dapt_cfg.svh ***
// register offsets, field positions and reset values of the dual autoreload pwm timer
`ifndef DAPT_CFG_SVH
`define DAPT_CFG_SVH
`define DAPT_AW 5
`define DAPT_A_CTRL 5'h00
`define DAPT_A_CTRL2 5'h01
`define DAPT_A_C1H 5'h02
`define DAPT_A_C1L 5'h03
`define DAPT_A_C2H 5'h04
`define DAPT_A_C2L 5'h05
`define DAPT_A_AR1H 5'h06
`define DAPT_A_AR1L 5'h07
`define DAPT_A_AR2H 5'h08
`define DAPT_A_AR2L 5'h09
`define DAPT_A_DUTY0 5'h0A
`define DAPT_A_DUTY_LAST 5'h11
`define DAPT_A_POL 5'h12
`define DAPT_A_CAPH 5'h13
`define DAPT_A_CAPL 5'h14
`define DAPT_A_BRKCTL 5'h15
`define DAPT_A_BRKEN 5'h16
`define DAPT_A_STAT 5'h17
`define DAPT_A_MASK 5'h18
`define DAPT_CNT_MAX 12'hFFF
`define DAPT_CNT_RST 12'h000
`define DAPT_CTRL_RST 8'h00
`define DAPT_CTRL2_RST 8'h03
`define DAPT_BRKEN_RST 8'h03
`define DAPT_BRKEN_MASK 8'h03
`define DAPT_BRKCTL_RST 8'h00
`define DAPT_ST_CMP_LSB 0
`define DAPT_ST_OVF1 4
`define DAPT_ST_OVF2 5
`define DAPT_ST_CAP 6
`endif

// *** pkg/dapt_pkg.sv ***
// types of the dual autoreload pwm timer
package dapt_pkg;
	typedef struct packed {
		logic [3:0] spare;
		logic capture_select;
		logic compare_irq_enable;
		logic dual_counter_enable;
		logic count_enable;
	} dapt_ctrl_type;
	typedef struct packed {
		logic [5:0] spare;
		logic transfer_two;
		logic transfer_one;
	} dapt_ctrl2_type;
	typedef struct packed {
		logic [3:0] level;
		logic [2:0] spare;
		logic break_active;
	} dapt_brkctl_type;
endpackage

// *** design/dapt_timer.sv ***
// dual 12-bit autoreload pwm timer with capture, break and byte register port
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "dapt_cfg.svh"
module dapt_timer import dapt_pkg::*; #(
	parameter int CH = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [`DAPT_AW-1:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rd_data_o,
	// pins
	input wire logic capture_pin_a_i,
	input wire logic capture_pin_b_i,
	input wire logic break_i,
	output logic [CH-1:0] pulse_output_o,
	output logic irq_o
);
	function automatic logic [7:0] hi_byte(input logic [11:0] v);
		return {4'h0, v[11:8]};
	endfunction
	function automatic logic [11:0] put_byte(input logic [11:0] v, input logic hi,
			input logic [7:0] d);
		return hi ? {d[3:0], v[7:0]} : {v[11:8], d};
	endfunction

	dapt_ctrl_type ctrl_q;
	dapt_ctrl2_type ctrl2_q;
	dapt_brkctl_type brkctl_q;
	logic [7:0] brken_q;
	logic [11:0] c1_q, c2_q, ar1_q, ar2_q, cap_q;
	logic [11:0] duty_pre_q [CH];
	logic [11:0] duty_act_q [CH];
	logic [CH-1:0] pol_pre_q, pol_act_q, raw_q, pulse_q;
	logic [6:0] st_q, msk_q, st_set;
	logic cap_prev_q, cap_vld_q;
	logic tick, tick2, ovf1, ovf2, cap_pin, cap_edge, brk_on;
	logic [CH-1:0] ch_ovf, ch_tran, ch_match, brk;
	logic [11:0] ch_cnt [CH];
	logic [`DAPT_AW-1:0] didx;

	assign tick = ctrl_q.count_enable;
	assign tick2 = tick && ctrl_q.dual_counter_enable;
	assign ovf1 = tick && (c1_q == `DAPT_CNT_MAX);
	assign ovf2 = tick2 && (c2_q == `DAPT_CNT_MAX);
	assign brk_on = brkctl_q.break_active | break_i;
	assign didx = addr_i - `DAPT_A_DUTY0;

	// channel routing: outputs 2 and 3 follow counter two only in dual mode
	always_comb begin
		for (int i = 0; i < CH; i++) begin
			if (i >= 2 && ctrl_q.dual_counter_enable) begin
				ch_ovf[i] = ovf2;
				ch_cnt[i] = c2_q;
				ch_tran[i] = ctrl2_q.transfer_two;
				brk[i] = brk_on & brken_q[1];
			end else begin
				ch_ovf[i] = ovf1;
				ch_cnt[i] = c1_q;
				ch_tran[i] = ctrl2_q.transfer_one;
				brk[i] = brk_on & brken_q[0];
			end
			ch_match[i] = (i >= 2 && ctrl_q.dual_counter_enable ? tick2 : tick)
				&& !ch_ovf[i] && (ch_cnt[i] == duty_act_q[i]);
		end
	end

	// counters: reload from autoreload, so period is 4096 minus autoreload
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			c1_q <= `DAPT_CNT_RST;
			c2_q <= `DAPT_CNT_RST;
		end else begin
			if (ovf1) begin
				c1_q <= ar1_q;
			end else if (tick) begin
				c1_q <= c1_q + 12'h001;
			end
			if (ovf2) begin
				c2_q <= ar2_q;
			end else if (tick2) begin
				c2_q <= c2_q + 12'h001;
			end
		end
	end

	// control registers written by software
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q <= `DAPT_CTRL_RST;
			ctrl2_q <= `DAPT_CTRL2_RST;
			brkctl_q <= `DAPT_BRKCTL_RST;
			brken_q <= `DAPT_BRKEN_RST;
			ar1_q <= `DAPT_CNT_RST;
			ar2_q <= `DAPT_CNT_RST;
			pol_pre_q <= '0;
			msk_q <= '0;
		end else if (wr_i) begin
			case (addr_i)
				`DAPT_A_CTRL: ctrl_q <= wr_data_i;
				`DAPT_A_CTRL2: ctrl2_q <= wr_data_i;
				`DAPT_A_BRKCTL: brkctl_q <= wr_data_i;
				// upper bits are not stored, so they always read back zero
				`DAPT_A_BRKEN: brken_q <= wr_data_i & `DAPT_BRKEN_MASK;
				`DAPT_A_AR1H, `DAPT_A_AR1L: begin
					ar1_q <= put_byte(ar1_q, addr_i == `DAPT_A_AR1H, wr_data_i);
				end
				`DAPT_A_AR2H, `DAPT_A_AR2L: begin
					ar2_q <= put_byte(ar2_q, addr_i == `DAPT_A_AR2H, wr_data_i);
				end
				`DAPT_A_POL: pol_pre_q <= wr_data_i[CH-1:0];
				`DAPT_A_MASK: msk_q <= wr_data_i[6:0];
				default: begin
				end
			endcase
		end
	end

	// duty preloads, one high/low byte pair per channel
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < CH; i++) begin
				duty_pre_q[i] <= `DAPT_CNT_RST;
			end
		end else if (wr_i && addr_i >= `DAPT_A_DUTY0 && addr_i <= `DAPT_A_DUTY_LAST) begin
			duty_pre_q[didx[2:1]] <= put_byte(duty_pre_q[didx[2:1]], !didx[0], wr_data_i);
		end
	end

	// active duty and polarity; with transfer set a preload takes effect only at its counter's overflow
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < CH; i++) begin
				duty_act_q[i] <= `DAPT_CNT_RST;
			end
			pol_act_q <= '0;
		end else begin
			for (int i = 0; i < CH; i++) begin
				if (ch_ovf[i] && ch_tran[i]) begin
					duty_act_q[i] <= duty_pre_q[i];
				end
				// with transfer clear the polarity follows software at once
				if (!ch_tran[i] || ch_ovf[i]) begin
					pol_act_q[i] <= pol_pre_q[i];
				end
			end
		end
	end

	// waveform: duty must not be below autoreload or the match never comes (software's job)
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			raw_q <= '0;
			pulse_q <= '0;
		end else begin
			for (int i = 0; i < CH; i++) begin
				if (ch_ovf[i]) begin
					raw_q[i] <= 1'b1;
				end else if (ch_match[i]) begin
					raw_q[i] <= 1'b0;
				end
				pulse_q[i] <= brk[i] ? brkctl_q.level[i] : raw_q[i] ^ pol_act_q[i];
			end
		end
	end
	assign pulse_output_o = pulse_q;

	// capture on either edge of the selected pin
	assign cap_pin = ctrl_q.capture_select ? capture_pin_b_i : capture_pin_a_i;
	assign cap_edge = cap_vld_q && (cap_pin != cap_prev_q);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cap_prev_q <= 1'b0;
			cap_vld_q <= 1'b0;
			cap_q <= `DAPT_CNT_RST;
		end else begin
			cap_prev_q <= cap_pin;
			cap_vld_q <= 1'b1;
			if (cap_edge && !st_q[`DAPT_ST_CAP]) begin
				cap_q <= c1_q;
			end
		end
	end

	// sticky status, write one to clear; a set in the same cycle wins
	always_comb begin
		st_set = '0;
		st_set[`DAPT_ST_CMP_LSB +: CH] = ch_match;
		st_set[`DAPT_ST_OVF1] = ovf1;
		st_set[`DAPT_ST_OVF2] = ovf2;
		st_set[`DAPT_ST_CAP] = cap_edge && !st_q[`DAPT_ST_CAP];
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else if (wr_i && addr_i == `DAPT_A_STAT) begin
			st_q <= (st_q & ~wr_data_i[6:0]) | st_set;
		end else begin
			st_q <= st_q | st_set;
		end
	end
	// compare flags need the compare enable as well as their mask bit
	assign irq_o = |(st_q & msk_q & {3'b111, {CH{ctrl_q.compare_irq_enable}}});

	// read data stand the cycle after the strobe; counter bytes are not latched
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				`DAPT_A_CTRL: rd_data_o <= ctrl_q;
				`DAPT_A_CTRL2: rd_data_o <= ctrl2_q;
				`DAPT_A_C1H: rd_data_o <= hi_byte(c1_q);
				`DAPT_A_C1L: rd_data_o <= c1_q[7:0];
				`DAPT_A_C2H: rd_data_o <= hi_byte(c2_q);
				`DAPT_A_C2L: rd_data_o <= c2_q[7:0];
				`DAPT_A_AR1H: rd_data_o <= hi_byte(ar1_q);
				`DAPT_A_AR1L: rd_data_o <= ar1_q[7:0];
				`DAPT_A_AR2H: rd_data_o <= hi_byte(ar2_q);
				`DAPT_A_AR2L: rd_data_o <= ar2_q[7:0];
				`DAPT_A_POL: rd_data_o <= {4'h0, pol_pre_q};
				`DAPT_A_CAPH: rd_data_o <= hi_byte(cap_q);
				`DAPT_A_CAPL: rd_data_o <= cap_q[7:0];
				`DAPT_A_BRKCTL: rd_data_o <= brkctl_q;
				`DAPT_A_BRKEN: rd_data_o <= brken_q;
				`DAPT_A_STAT: rd_data_o <= {1'b0, st_q};
				`DAPT_A_MASK: rd_data_o <= {1'b0, msk_q};
				default: begin
					if (addr_i >= `DAPT_A_DUTY0 && addr_i <= `DAPT_A_DUTY_LAST) begin
						rd_data_o <= didx[0] ? duty_pre_q[didx[2:1]][7:0]
							: hi_byte(duty_pre_q[didx[2:1]]);
					end else begin
						rd_data_o <= 8'h00;
					end
				end
			endcase
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_ovf0_high;
		ch_ovf[0] ##1 raw_q[0];
	endsequence

	AST_RELOAD: assert property (ovf1 |=> c1_q == $past(ar1_q))
		else $error("counter one did not reload from autoreload");
	AST_COUNT: assert property (tick && !ovf1 |=> c1_q == $past(c1_q) + 12'h001)
		else $error("counter one did not count up");
	AST_DUTY_XFER: assert property (ch_ovf[0] && ch_tran[0]
			|=> duty_act_q[0] == $past(duty_pre_q[0]))
		else $error("duty preload not transferred at overflow");
	AST_DUTY_HOLD: assert property (!ch_ovf[0] |=> $stable(duty_act_q[0]))
		else $error("active duty changed outside overflow");
	AST_PWM_HIGH: assert property (ch_ovf[0] |-> s_ovf0_high)
		else $error("output not set at overflow");
	AST_PWM_LOW: assert property (ch_match[0] ##1 !ch_ovf[0] |-> !raw_q[0] ##1 !raw_q[0])
		else $error("output not cleared at duty match");
	AST_POL_SYNC: assert property (ch_tran[0] && !ch_ovf[0] |=> $stable(pol_act_q[0]))
		else $error("polarity changed away from overflow");
	AST_CAP_TAKE: assert property (cap_edge && !st_q[`DAPT_ST_CAP]
			|=> cap_q == $past(c1_q) && st_q[`DAPT_ST_CAP])
		else $error("capture did not take counter one");
	AST_CAP_HOLD: assert property (st_q[`DAPT_ST_CAP] |=> $stable(cap_q))
		else $error("capture overwritten while flag set");
	AST_BREAK: assert property (brk[2] |=> pulse_q[2] == $past(brkctl_q.level[2]))
		else $error("break did not force output two");
	AST_OVF_FLAG: assert property (ovf1 |=> st_q[`DAPT_ST_OVF1])
		else $error("overflow flag not raised");
	AST_IRQ_GATE: assert property (!ctrl_q.compare_irq_enable && (st_q[6:4] & msk_q[6:4]) == 3'h0
			|-> !irq_o)
		else $error("compare flag passed while compare interrupt disabled");
endmodule

// *** dv/dapt_bridge.sv ***
// half-bridge stage model that times the high side drive of one leg
`timescale 1ns/10ps
module dapt_bridge (
	// clock
	input wire logic clk_i,
	// gate drive from the timer
	input wire logic [3:0] gate_i,
	// measured period and on-time of leg 0, in clock cycles
	output logic [15:0] period_o,
	output logic [15:0] high_o
);
	logic prev_q;
	logic [15:0] cnt_q;
	logic [15:0] hcnt_q;
	// the stage only switches on a rising gate, so each period runs rise to rise
	always_ff @(posedge clk_i) begin
		prev_q <= gate_i[0];
		if (gate_i[0] && !prev_q) begin
			period_o <= cnt_q;
			high_o <= hcnt_q;
			cnt_q <= 16'h0001;
			hcnt_q <= 16'h0001;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			hcnt_q <= hcnt_q + {15'h0000, gate_i[0]};
		end
	end
	initial begin
		prev_q = 1'b0;
		cnt_q = 16'h0000;
		hcnt_q = 16'h0000;
		period_o = 16'h0000;
		high_o = 16'h0000;
	end
endmodule

// *** dv/tb_top.sv ***
// self-checking bench of the dual autoreload pwm timer
`timescale 1ns/10ps
`include "dapt_cfg.svh"
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] addr = 5'h00;
	logic [7:0] wd = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic pa = 1'b0;
	logic pb = 1'b0;
	logic brk = 1'b0;
	wire [7:0] rdat;
	wire [3:0] pwm;
	wire irq;
	wire [15:0] per;
	wire [15:0] hi;
	int error_cnt = 0;
	int checks = 0;
	logic [15:0] v;
	logic [15:0] x1;
	logic [15:0] x2;
	always #10 clk = ~clk;
	dapt_timer i_dut (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wr_data_i(wd),
		.wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .capture_pin_a_i(pa),
		.capture_pin_b_i(pb), .break_i(brk), .pulse_output_o(pwm), .irq_o(irq));
	dapt_bridge i_stage (.clk_i(clk), .gate_i(pwm), .period_o(per), .high_o(hi));
	task automatic wr8(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd8(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = {8'h00, rdat};
	endtask
	// low byte first, since the counter bytes are not latched
	task automatic rd12(input logic [4:0] a, output logic [15:0] d);
		logic [15:0] l;
		logic [15:0] h;
		rd8(a + 5'h01, l);
		rd8(a, h);
		d = {h[7:0], l[7:0]};
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	initial begin
		// the whole run needs about 9000 clock cycles
		#400000;
		error_cnt++;
		conclude;
	end
	initial begin
		tick(8);
		rst <= 1'b0;
		rd12(`DAPT_A_C1H, v); chk(v, 16'h0000);
		rd12(`DAPT_A_CAPH, v); chk(v, 16'h0000);
		rd8(`DAPT_A_BRKEN, v); chk(v, 16'h0003);
		rd8(`DAPT_A_CTRL2, v); chk(v, 16'h0003);
		wr8(`DAPT_A_C1L, 8'h55);
		rd12(`DAPT_A_C1H, v); chk(v, 16'h0000);
		rd8(5'h1F, v); chk(v, 16'h0000);
		wr8(`DAPT_A_BRKEN, 8'hFF);
		rd8(`DAPT_A_BRKEN, v); chk(v, 16'h0003);
		// duty stays above autoreload so the leg toggles
		wr8(`DAPT_A_AR1H, 8'h0F);
		wr8(`DAPT_A_AR1L, 8'hFA);
		wr8(`DAPT_A_DUTY0, 8'h0F);
		wr8(`DAPT_A_DUTY0 + 5'h01, 8'hFD);
		wr8(`DAPT_A_MASK, 8'h11);
		wr8(`DAPT_A_CTRL, 8'h01);
		// first overflow only after counting all 4096 steps from zero
		tick(4200);
		chk(per, 16'h0006);
		chk(hi, 16'h0004);
		rd8(`DAPT_A_STAT, v); chk(v & 16'h0011, 16'h0011);
		wr8(`DAPT_A_MASK, 8'h01);
		chk({15'h0000, irq}, 16'h0000);
		wr8(`DAPT_A_CTRL, 8'h05);
		chk({15'h0000, irq}, 16'h0001);
		wr8(`DAPT_A_CTRL, 8'h04);
		wr8(`DAPT_A_STAT, 8'hFF);
		chk({15'h0000, irq}, 16'h0000);
		wr8(`DAPT_A_CTRL, 8'h01);
		wr8(`DAPT_A_POL, 8'h01);
		tick(30);
		chk(hi, 16'h0002);
		wr8(`DAPT_A_CTRL, 8'h00);
		rd12(`DAPT_A_C1H, x1);
		@(posedge clk) pa <= 1'b1;
		tick(2);
		rd12(`DAPT_A_CAPH, v); chk(v, x1);
		wr8(`DAPT_A_CTRL, 8'h01);
		tick(3);
		wr8(`DAPT_A_CTRL, 8'h00);
		rd12(`DAPT_A_C1H, x2);
		@(posedge clk) pa <= 1'b0;
		tick(2);
		rd12(`DAPT_A_CAPH, v); chk(v, x1);
		wr8(`DAPT_A_STAT, 8'h40);
		@(posedge clk) pa <= 1'b1;
		tick(2);
		rd12(`DAPT_A_CAPH, v); chk(v, x2);
		wr8(`DAPT_A_BRKCTL, 8'h50);
		wr8(`DAPT_A_BRKEN, 8'h01);
		@(posedge clk) brk <= 1'b1;
		tick(3);
		chk({12'h000, pwm}, 16'h0005);
		wr8(`DAPT_A_BRKEN, 8'h02);
		wr8(`DAPT_A_CTRL, 8'h02);
		tick(3);
		chk({14'h0000, pwm[3:2]}, 16'h0001);
		// switching to pin b while the flag is set hides the false edge of the swap
		wr8(`DAPT_A_CTRL, 8'h0A);
		wr8(`DAPT_A_STAT, 8'h40);
		rd12(`DAPT_A_C1H, x1);
		@(posedge clk) pb <= 1'b1;
		tick(2);
		rd12(`DAPT_A_CAPH, v); chk(v, x1);
		@(posedge clk) brk <= 1'b0;
		wr8(`DAPT_A_BRKCTL, 8'h01);
		tick(2);
		chk({14'h0000, pwm[3:2]}, 16'h0000);
		wr8(`DAPT_A_BRKCTL, 8'h00);
		// counter two runs from zero in dual mode and reloads from its own value
		wr8(`DAPT_A_AR2H, 8'h0F);
		wr8(`DAPT_A_AR2L, 8'hFA);
		wr8(`DAPT_A_CTRL, 8'h03);
		tick(4200);
		wr8(`DAPT_A_CTRL, 8'h02);
		rd8(`DAPT_A_STAT, v); chk(v & 16'h0020, 16'h0020);
		rd12(`DAPT_A_C2H, v); chk({15'h0000, v >= 16'h0FFA}, 16'h0001);
		// a second reset in mid-run brings everything back to its reset state
		@(posedge clk) rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		rd12(`DAPT_A_C1H, v); chk(v, 16'h0000);
		rd8(`DAPT_A_BRKEN, v); chk(v, 16'h0003);
		conclude;
	end
endmodule
